// file: inc/oct_pkg.sv
// Constants, register map and types of the overcurrent trip logic
package oct_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_NS     = 5;          // Clock period in ns
  localparam int unsigned MS_NS      = 1000000;    // One millisecond in ns
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [15:0] REL_LONG_MS  = 16'h00c8; // 200 ms contact release
  localparam logic [15:0] REL_SHORT_MS = 16'h0032; // 50 ms contact release
  localparam logic [15:0] RST_FULL_MS  = 16'h1f40; // 8000 ms unwind at M=10
  localparam logic [15:0] BLINK_MS     = 16'h00fa; // LED blink half period
  localparam logic [23:0] SCALE_DIV    = 24'h000064; // M/10 and tenth steps
  localparam logic [3:0]  STEPS        = 4'ha;     // Elapsed count end value

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NPH   = 3;               // Phases of timed element
  localparam int unsigned NELEM = NPH + 1;         // Plus instantaneous
  localparam int unsigned NOUT  = 6;               // Programmable outputs
  localparam int unsigned NHIST = 5;               // Indication history
  localparam logic [3:0]  CURVE_MAX = 4'hb;        // 11 inverse + definite

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_MULT   = 8'h04;
  localparam logic [7:0] A_INST   = 8'h08;
  localparam logic [7:0] A_MAP    = 8'h0c;
  localparam logic [7:0] A_OUTCFG = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_IND    = 8'h18;
  localparam logic [7:0] A_HIST0  = 8'h20;
  localparam logic [7:0] HIST_STRIDE = 8'h04;
  localparam int unsigned FORCE_LSB = 8;           // OUTCFG force field
  localparam int unsigned ST_LAPSE  = 4;           // STATUS field positions
  localparam int unsigned ST_OUT    = 8;
  localparam int unsigned ST_HELD   = 14;

  // Reset characteristic, codes 01, 11 and 21 of the relay
  typedef enum logic [1:0] {
    RC_DEF200 = 2'b00,
    RC_INV    = 2'b01,
    RC_DEF50  = 2'b11
  } oct_rc_t;

  typedef struct packed {
    logic       ind_auto;   // 1: indicator auto reset, 0: self-hold
    oct_rc_t    rst_char;
    logic [3:0] curve;
    logic       lock_inst;  // Instantaneous setting at lock
    logic       lock_td;    // Time-delayed setting at lock
  } oct_cfg_t;

  localparam int unsigned CFG_W = $bits(oct_cfg_t);
  localparam oct_cfg_t    CFG_RST = '{1'b0, RC_DEF200, 4'h0, 1'b0, 1'b0};
  localparam logic [7:0]  MULT_RST = 8'h0a;
  localparam logic [15:0] INST_RST = 16'h0000;
  localparam logic [23:0] MAP_RST  = 24'hffffff;

endpackage

// file: verilog/oct_relay.sv
// Overcurrent trip timing, indication and programmable outputs
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
module oct_relay #(
  parameter int unsigned CYC_PER_MS = oct_pkg::CYC_PER_MS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_CE,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic [2:0]  I_PH_OVER,
  input  wire logic        I_INST_OVER,
  input  wire logic [15:0] I_BASE_MS,
  input  wire logic        I_IND_RST,
  output logic      [3:0]  O_CURVE_SEL,
  output logic      [3:0]  O_ELEM,
  output logic      [3:0]  O_LAPSE,
  output logic      [5:0]  O_OUT,
  output logic      [5:0]  O_LED_OUT,
  output logic             O_LED_TD,
  output logic             O_LED_INST
);

  localparam int unsigned PRE_W = $clog2(CYC_PER_MS);
  localparam int unsigned NPH   = oct_pkg::NPH;
  localparam int unsigned NEL   = oct_pkg::NELEM;
  localparam int unsigned NOUT  = oct_pkg::NOUT;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Scale a time by M/10 and split into tenths, never below 1 ms
  function automatic logic [15:0] scale_ms(input logic [15:0] base,
                                           input logic [7:0]  m);
    logic [23:0] prod;
    prod = (24'(base) * 24'(m)) / oct_pkg::SCALE_DIV;
    if (prod[23:16] != 8'h00) begin
      scale_ms = 16'hffff;
    end else if (prod[15:0] == 16'h0000) begin
      scale_ms = 16'h0001;
    end else begin
      scale_ms = prod[15:0];
    end
  endfunction

  // Largest elapsed count over the phases
  function automatic logic [3:0] max_cnt(input logic [NPH-1:0][3:0] c);
    max_cnt = 4'h0;
    for (int p = 0; p < NPH; p++) begin
      if (c[p] > max_cnt) begin
        max_cnt = c[p];
      end
    end
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  oct_pkg::oct_cfg_t         cfg;
  logic [7:0]                mult;
  logic [15:0]               inst_ms;
  logic [NOUT-1:0][NEL-1:0]  omap;
  logic [NOUT-1:0]           hold_en;
  logic [NOUT-1:0]           force_on;
  logic [NEL-1:0]            held;
  logic [NEL-1:0]            hist [oct_pkg::NHIST];
  logic [PRE_W-1:0]          pre;
  logic                      tick;
  logic [NPH-1:0][3:0]       cnt;
  logic [NPH-1:0][15:0]      acc;
  logic [NPH-1:0][15:0]      rel;
  logic [NPH-1:0]            td_op;
  logic [15:0]               inst_acc;
  logic                      inst_op;
  logic [NEL-1:0]            elem_q;
  logic [NOUT-1:0]           latch;
  logic                      sw_s1;
  logic                      sw_s2;
  logic                      sw_q;
  logic [15:0]               blink_acc;
  logic                      blink;
  logic [NEL-1:0]            elem;
  logic                      press;
  logic                      event_new;
  logic [15:0]               step_ms;
  logic [15:0]               ustep_ms;
  logic [15:0]               rel_ms;
  logic [NOUT-1:0]           next_out;
  logic [31:0]               rd_mux;
  oct_pkg::oct_cfg_t         wr_cfg;

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************

  // Element operation vector, instantaneous on top
  assign elem      = {inst_op, td_op};
  assign event_new = |(elem & ~elem_q);
  assign press     = sw_s2 & ~sw_q;
  assign wr_cfg    = oct_pkg::oct_cfg_t'(I_WDATA[oct_pkg::CFG_W-1:0]);

  // Tenth of the operating time and of the unwind time
  assign step_ms  = scale_ms(I_BASE_MS, mult);
  assign ustep_ms = scale_ms(oct_pkg::RST_FULL_MS, mult);

  // Contact release delay per reset characteristic
  assign rel_ms = (cfg.rst_char == oct_pkg::RC_DEF50) ?
                  oct_pkg::REL_SHORT_MS :
                  oct_pkg::REL_LONG_MS;

  // Output OR logic, self-hold latch and forcing
  always_comb begin
    for (int k = 0; k < NOUT; k++) begin
      next_out[k] = |(omap[k] & elem);
    end
    next_out = next_out | latch | force_on;
  end

  // ****************************************************************
  // Millisecond tick and blink phase
  // ****************************************************************

  // Prescaler from the system clock
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pre  <= '0;
      tick <= 1'b0;
    end else if (I_CE) begin
      if (pre == PRE_W'(CYC_PER_MS - 1)) begin
        pre  <= '0;
        tick <= 1'b1;
      end else begin
        pre  <= pre + PRE_W'(1);
        tick <= 1'b0;
      end
    end
  end

  // Blink phase for the starting indication
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      blink_acc <= '0;
      blink     <= 1'b0;
    end else if (I_CE && tick) begin
      if (blink_acc + 16'h0001 >= oct_pkg::BLINK_MS) begin
        blink_acc <= '0;
        blink     <= ~blink;
      end else begin
        blink_acc <= blink_acc + 16'h0001;
      end
    end
  end

  // Indicator reset switch, two stage synchroniser and edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_q  <= 1'b0;
    end else if (I_CE) begin
      sw_s1 <= I_IND_RST;
      sw_s2 <= sw_s1;
      sw_q  <= sw_s2;
    end
  end

  // ****************************************************************
  // Time-delayed element, one timer per phase
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cnt   <= '0;
      acc   <= '0;
      rel   <= '0;
      td_op <= '0;
    end else if (I_CE) begin
      for (int p = 0; p < NPH; p++) begin
        if (cfg.lock_td) begin
          cnt[p]   <= '0;
          acc[p]   <= '0;
          rel[p]   <= '0;
          td_op[p] <= 1'b0;
        end else if (I_PH_OVER[p]) begin
          // Above setting: count tenths of the operating time
          rel[p] <= '0;
          // A timer still at full after an inverse unwind trips again at once
          if (cnt[p] == oct_pkg::STEPS) begin
            td_op[p] <= 1'b1;
          end
          if (tick && cnt[p] != oct_pkg::STEPS) begin
            if (acc[p] + 16'h0001 >= step_ms) begin
              acc[p] <= '0;
              cnt[p] <= cnt[p] + 4'h1;
              if (cnt[p] + 4'h1 == oct_pkg::STEPS) begin
                td_op[p] <= 1'b1;
              end
            end else begin
              acc[p] <= acc[p] + 16'h0001;
            end
          end
        end else begin
          // Below setting: timer reset per characteristic
          if (cfg.rst_char == oct_pkg::RC_INV) begin
            if (tick && cnt[p] != 4'h0) begin
              if (acc[p] + 16'h0001 >= ustep_ms) begin
                acc[p] <= '0;
                cnt[p] <= cnt[p] - 4'h1;
              end else begin
                acc[p] <= acc[p] + 16'h0001;
              end
            end
          end else begin
            cnt[p] <= '0;
            acc[p] <= '0;
          end
          // Contact drops a fixed time after the current falls
          if (td_op[p] && tick) begin
            if (rel[p] + 16'h0001 >= rel_ms) begin
              rel[p]   <= '0;
              td_op[p] <= 1'b0;
            end else begin
              rel[p] <= rel[p] + 16'h0001;
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Instantaneous element
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      inst_acc <= '0;
      inst_op  <= 1'b0;
    end else if (I_CE) begin
      if (cfg.lock_inst || !I_INST_OVER) begin
        inst_acc <= '0;
        inst_op  <= 1'b0;
      end else if (inst_acc >= inst_ms) begin
        inst_op <= 1'b1;
      end else if (tick) begin
        inst_acc <= inst_acc + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Indication hold and history
  // ****************************************************************

  // Held indication; a new operation wins over the reset switch
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      held <= '0;
    end else if (I_CE) begin
      if (I_WR && I_ADDR == oct_pkg::A_IND) begin
        held <= I_WDATA[NEL-1:0];
      end else begin
        held <= (press ? '0 : held) |
                (cfg.ind_auto ? '0 : elem);
      end
    end
  end

  // Five deep history, newest in slot 0
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      elem_q <= '0;
      for (int h = 0; h < oct_pkg::NHIST; h++) begin
        hist[h] <= '0;
      end
    end else if (I_CE) begin
      elem_q <= elem;
      if (event_new) begin
        hist[0] <= elem;
        for (int h = 1; h < oct_pkg::NHIST; h++) begin
          hist[h] <= hist[h-1];
        end
      end
    end
  end

  // ****************************************************************
  // Programmable outputs and lamps
  // ****************************************************************

  // Self-hold latch; operation wins over the reset switch
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      latch <= '0;
    end else if (I_CE) begin
      for (int k = 0; k < NOUT; k++) begin
        latch[k] <= (latch[k] & ~press) |
                    (hold_en[k] & |(omap[k] & elem));
      end
    end
  end

  // Registered outputs and lamps
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_OUT       <= '0;
      O_LED_OUT   <= '0;
      O_LED_TD    <= 1'b0;
      O_LED_INST  <= 1'b0;
      O_ELEM      <= '0;
      O_LAPSE     <= '0;
      O_CURVE_SEL <= '0;
    end else if (I_CE) begin
      O_OUT     <= next_out;
      O_LED_OUT <= (|force_on) ? next_out : '0;
      if (|td_op || |held[NPH-1:0]) begin
        O_LED_TD <= 1'b1;
      end else begin
        O_LED_TD <= blink & ~cfg.lock_td & (|I_PH_OVER);
      end
      O_LED_INST  <= inst_op | held[NPH];
      O_ELEM      <= elem;
      O_LAPSE     <= max_cnt(cnt);
      O_CURVE_SEL <= cfg.curve;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************

  // Software writes; illegal curve or reset codes are ignored
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cfg      <= oct_pkg::CFG_RST;
      mult     <= oct_pkg::MULT_RST;
      inst_ms  <= oct_pkg::INST_RST;
      omap     <= oct_pkg::MAP_RST;
      hold_en  <= '0;
      force_on <= '0;
    end else if (I_CE && I_WR) begin
      unique case (I_ADDR)
        oct_pkg::A_CTRL: begin
          cfg.lock_td   <= wr_cfg.lock_td;
          cfg.lock_inst <= wr_cfg.lock_inst;
          cfg.ind_auto  <= wr_cfg.ind_auto;
          if (wr_cfg.curve <= oct_pkg::CURVE_MAX) begin
            cfg.curve <= wr_cfg.curve;
          end
          if (wr_cfg.rst_char inside {oct_pkg::RC_DEF200, oct_pkg::RC_INV,
                                      oct_pkg::RC_DEF50}) begin
            cfg.rst_char <= wr_cfg.rst_char;
          end
        end
        oct_pkg::A_MULT:   mult    <= I_WDATA[7:0];
        oct_pkg::A_INST:   inst_ms <= I_WDATA[15:0];
        oct_pkg::A_MAP:    omap    <= I_WDATA[NOUT*NEL-1:0];
        oct_pkg::A_OUTCFG: begin
          hold_en  <= I_WDATA[NOUT-1:0];
          force_on <= I_WDATA[oct_pkg::FORCE_LSB +: NOUT];
        end
        default: ;
      endcase
    end
  end

  // Read selection; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    unique case (I_ADDR)
      oct_pkg::A_CTRL:   rd_mux[oct_pkg::CFG_W-1:0] = cfg;
      oct_pkg::A_MULT:   rd_mux[7:0] = mult;
      oct_pkg::A_INST:   rd_mux[15:0] = inst_ms;
      oct_pkg::A_MAP:    rd_mux[NOUT*NEL-1:0] = omap;
      oct_pkg::A_OUTCFG: begin
        rd_mux[NOUT-1:0] = hold_en;
        rd_mux[oct_pkg::FORCE_LSB +: NOUT] = force_on;
      end
      oct_pkg::A_STATUS: begin
        rd_mux[NEL-1:0] = elem;
        rd_mux[oct_pkg::ST_LAPSE +: 4] = max_cnt(cnt);
        rd_mux[oct_pkg::ST_OUT +: NOUT] = O_OUT;
        rd_mux[oct_pkg::ST_HELD +: NEL] = held;
      end
      oct_pkg::A_IND:    rd_mux[NEL-1:0] = held;
      default: begin
        for (int h = 0; h < oct_pkg::NHIST; h++) begin
          if (I_ADDR == oct_pkg::A_HIST0 + 8'(h) * oct_pkg::HIST_STRIDE) begin
            rd_mux[NEL-1:0] = hist[h];
          end
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= '0;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? rd_mux : '0;
    end
  end

endmodule

// file: verification/oct_front_model.sv
// Comparator front end and curve evaluator model feeding the trip logic
`timescale 1ns/100ps
module oct_front_model (
  input  wire logic        i_clk,
  input  wire logic [3:0]  i_over_cmd,
  input  wire logic [3:0]  i_curve_sel,
  output logic      [2:0]  o_ph_over,
  output logic             o_inst_over,
  output logic      [15:0] o_base_ms
);
  // Comparators settle one clock after the current changes
  always_ff @(posedge i_clk) begin
    o_ph_over   <= i_over_cmd[2:0];
    o_inst_over <= i_over_cmd[3];
    o_base_ms   <= 16'h000a + 16'h0028 * {12'h000, i_curve_sel};
  end
endmodule

// file: verification/oct_relay_assertions.sv
// Concurrent checks on the ports of the overcurrent trip logic
`timescale 1ns/100ps
module oct_relay_assertions #(
  parameter int unsigned CYC_PER_MS = 20
) (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_CE,
  input wire logic        I_RD,
  input wire logic [2:0]  I_PH_OVER,
  input wire logic        I_INST_OVER,
  input wire logic [31:0] O_RDATA,
  input wire logic [3:0]  O_CURVE_SEL,
  input wire logic [3:0]  O_ELEM,
  input wire logic [3:0]  O_LAPSE,
  input wire logic [5:0]  O_OUT,
  input wire logic [5:0]  O_LED_OUT,
  input wire logic        O_LED_TD,
  input wire logic        O_LED_INST
);
  logic [31:0] low_cnt;

  // Cycles since phase A fell below its setting
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_PH_OVER[0]) low_cnt <= 32'h0;
    else if (I_CE) low_cnt <= low_cnt + 32'h1;
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST || !I_CE);

  property p_rdata_idle; !$past(I_RD) |-> O_RDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  property p_lapse_max; O_LAPSE <= 4'ha; endproperty
  a_lapse_max: assert property (p_lapse_max)
    else $error("elapsed count above end value");
  property p_lapse_step; O_LAPSE > $past(O_LAPSE) |-> O_LAPSE == $past(O_LAPSE) + 4'h1; endproperty
  a_lapse_step: assert property (p_lapse_step)
    else $error("elapsed count jumped");
  property p_trip_ten; $rose(|O_ELEM[2:0]) |-> O_LAPSE == 4'ha || $past(O_LAPSE) == 4'ha;
  endproperty
  a_trip_ten: assert property (p_trip_ten)
    else $error("timed operation without count ten");
  property p_inst_led; $rose(O_ELEM[3]) |-> ##[0:2] O_LED_INST; endproperty
  a_inst_led: assert property (p_inst_led)
    else $error("instantaneous indicator not lit");
  property p_td_led; $rose(|O_ELEM[2:0]) |-> ##[0:2] O_LED_TD [*4]; endproperty
  a_td_led: assert property (p_td_led)
    else $error("timed indicator not steady on operation");
  property p_inst_drop; !I_INST_OVER [*3] |=> !O_ELEM[3]; endproperty
  a_inst_drop: assert property (p_inst_drop)
    else $error("instantaneous operation without current");
  property p_led_out; O_LED_OUT != 6'h00 |-> O_LED_OUT == O_OUT; endproperty
  a_led_out: assert property (p_led_out)
    else $error("output indicators differ from outputs");
  property p_curve; O_CURVE_SEL <= 4'hb; endproperty
  a_curve: assert property (p_curve)
    else $error("curve selection out of range");
  property p_rel_time;
    $fell(O_ELEM[0]) |-> low_cnt >= 49 * CYC_PER_MS && low_cnt <= 202 * CYC_PER_MS;
  endproperty
  a_rel_time: assert property (p_rel_time)
    else $error("phase release time outside window");

  c_trip: cover property ($rose(O_ELEM[0]));
  c_inst: cover property ($rose(O_ELEM[3]));
  c_force: cover property (O_LED_OUT != 6'h00);
endmodule

bind oct_relay oct_relay_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_RD(I_RD), .I_PH_OVER(I_PH_OVER),
  .I_INST_OVER(I_INST_OVER), .O_RDATA(O_RDATA), .O_CURVE_SEL(O_CURVE_SEL),
  .O_ELEM(O_ELEM), .O_LAPSE(O_LAPSE), .O_OUT(O_OUT), .O_LED_OUT(O_LED_OUT),
  .O_LED_TD(O_LED_TD), .O_LED_INST(O_LED_INST)
);

// file: verification/oct_relay_bench.sv
// Self-checking bench of the overcurrent trip logic
`timescale 1ns/100ps
module oct_relay_bench;
  localparam int unsigned CPM = 20;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } oct_row_t;
  logic        clk;
  logic        rst      = 1'b1;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        ind_rst  = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  over_cmd = 4'h0;
  logic [31:0] rdata;
  logic [2:0]  ph_over;
  logic        inst_over;
  logic [15:0] base_ms;
  logic [3:0]  curve_sel;
  logic [3:0]  elem;
  logic [3:0]  lapse;
  logic [5:0]  outs;
  logic [5:0]  led_out;
  logic        led_td;
  logic        led_inst;
  logic        led_prev;
  logic [31:0] got;
  logic [3:0]  hseq [6] = '{4'h8, 4'h2, 4'h4, 4'h8, 4'h2, 4'h4};
  logic [3:0]  hexp [5] = '{4'h4, 4'h2, 4'h8, 4'h4, 4'h2};
  int          fails       = 0;
  int          checks_done = 0;
  int          blinks      = 0;
  int          n;
  oct_row_t    rows [13];

  oct_relay #(.CYC_PER_MS(CPM)) dut (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_PH_OVER(ph_over), .I_INST_OVER(inst_over),
    .I_BASE_MS(base_ms), .I_IND_RST(ind_rst), .O_CURVE_SEL(curve_sel), .O_ELEM(elem),
    .O_LAPSE(lapse), .O_OUT(outs), .O_LED_OUT(led_out), .O_LED_TD(led_td),
    .O_LED_INST(led_inst)
  );
  oct_front_model u_front (
    .i_clk(clk), .i_over_cmd(over_cmd), .i_curve_sel(curve_sel), .o_ph_over(ph_over),
    .o_inst_over(inst_over), .o_base_ms(base_ms)
  );

  // Clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Indicator changes while phase A starts but has not operated
  always @(posedge clk) begin
    if (over_cmd[0] && elem === 4'h0 && led_td !== led_prev) blinks++;
    led_prev <= led_td;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_rng(input int g, input int lo, input int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      fails++;
      $display("mismatch at %0t got %h expected %h to %h", $time, g, lo, hi);
    end
  endtask

  // Register bus cycles, each leaves one idle cycle behind
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Bounded wait for the OR of the masked elements to reach a level
  task automatic wait_on(input logic [3:0] m, input logic v, input int lim, output int k);
    k = 0;
    while ((|(elem & m)) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      fails++;
      close_out();
    end
  endtask

  task automatic ev(input logic [3:0] m);
    over_cmd <= m;
    wait_on(m, 1'b1, 5000, n);
    over_cmd <= 4'h0;
    wait_on(m, 1'b0, 5000, n);
  endtask

  task automatic press_ind();
    ind_rst <= 1'b1;
    repeat (4) @(posedge clk);
    ind_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Phase A trip and release under one reset characteristic
  task automatic trip(input logic [1:0] code, input logic [3:0] crv, input logic [7:0] m,
                      input int rel, input logic zero_after);
    int st;
    int t;
    st = (10 + 40 * crv) * m / 100;
    if (st < 1) st = 1;
    t = 10 * st * CPM;
    wr_reg(oct_pkg::A_CTRL, {24'h0, code, crv, 2'b00});
    wr_reg(oct_pkg::A_MULT, {24'h0, m});
    blinks = 0;
    over_cmd <= 4'h1;
    wait_on(4'h1, 1'b1, 2 * t, n);
    check_rng(n, t - CPM - 2, t + CPM + 8);
    repeat (2) @(posedge clk);
    check_eq(lapse, 4'ha);
    check_eq(outs, 6'h3f);
    check_eq(led_td, 1'b1);
    if (t > 600 * CPM) check_eq(blinks > 2, 1'b1);
    over_cmd <= 4'h0;
    repeat (5) @(posedge clk);
    check_eq(lapse == 4'h0, zero_after);
    wait_on(4'h1, 1'b0, 2 * rel * CPM, n);
    check_rng(n + 5, rel * CPM - CPM - 2, rel * CPM + CPM + 8);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows = '{'{1'b0, oct_pkg::A_CTRL, 32'h0, 32'h0}, '{1'b0, oct_pkg::A_MULT, 32'h0, 32'h0a},
      '{1'b0, oct_pkg::A_INST, 32'h0, 32'h0}, '{1'b0, oct_pkg::A_MAP, 32'h0, 32'hffffff},
      '{1'b0, oct_pkg::A_OUTCFG, 32'h0, 32'h0}, '{1'b0, oct_pkg::A_STATUS, 32'h0, 32'h0},
      '{1'b0, oct_pkg::A_IND, 32'h0, 32'h0}, '{1'b0, 8'hfc, 32'h0, 32'h0},
      '{1'b1, oct_pkg::A_STATUS, 32'hffffffff, 32'h0}, '{1'b1, oct_pkg::A_MULT, 32'h14, 32'h14},
      '{1'b1, oct_pkg::A_CTRL, 32'h2c, 32'h2c}, '{1'b1, oct_pkg::A_CTRL, 32'h30, 32'h2c},
      '{1'b1, oct_pkg::A_CTRL, 32'hac, 32'h2c}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check_eq({elem, outs}, 10'h000);
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, got);
      check_eq(got, rows[i].e);
    end
    check_eq(curve_sel, 4'hb);
    trip(2'b00, 4'hb, 8'h14, 200, 1'b1);
    check_eq(led_td, 1'b1);
    press_ind();
    check_eq(led_td, 1'b0);
    trip(2'b11, 4'h0, 8'h0a, 50, 1'b1);
    trip(2'b01, 4'h0, 8'h14, 200, 1'b0);
    over_cmd <= 4'h1;
    wait_on(4'h1, 1'b1, 8, n);
    check_eq(lapse, 4'ha);
    over_cmd <= 4'h0;
    wait_on(4'h1, 1'b0, 400 * CPM, n);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_eq(lapse, 4'h0);
    wr_reg(oct_pkg::A_CTRL, 32'h000000c0);
    wr_reg(oct_pkg::A_MULT, 32'h00000001);
    foreach (hseq[i]) ev(hseq[i]);
    for (int i = 0; i < 5; i++) begin
      rd_reg(oct_pkg::A_HIST0 + oct_pkg::HIST_STRIDE * 8'(i), got);
      check_eq(got, {28'h0, hexp[i]});
    end
    wr_reg(oct_pkg::A_MAP, 32'h00111118);
    wr_reg(oct_pkg::A_INST, 32'h00000002);
    over_cmd <= 4'h8;
    wait_on(4'h8, 1'b1, 8 * CPM, n);
    check_rng(n, CPM - 2, 3 * CPM + 8);
    repeat (2) @(posedge clk);
    check_eq(outs, 6'h01);
    check_eq(led_inst, 1'b1);
    over_cmd <= 4'h0;
    repeat (4) @(posedge clk);
    check_eq(outs, 6'h00);
    wr_reg(oct_pkg::A_OUTCFG, 32'h00000001);
    ev(4'h8);
    repeat (2) @(posedge clk);
    check_eq(outs, 6'h01);
    press_ind();
    check_eq(outs, 6'h00);
    wr_reg(oct_pkg::A_CTRL, 32'h00000002);
    over_cmd <= 4'h8;
    repeat (200) @(posedge clk);
    check_eq(elem, 4'h0);
    over_cmd <= 4'h0;
    wr_reg(oct_pkg::A_OUTCFG, 32'h00002400);
    repeat (2) @(posedge clk);
    check_eq({led_out, outs}, 12'h924);
    wr_reg(oct_pkg::A_OUTCFG, 32'h00000000);
    repeat (2) @(posedge clk);
    check_eq(led_out, 6'h00);
    close_out();
  end
endmodule
